// [pkg/but_pkg.sv]
// Function
// - Reload buffer bit selects shadowed reload
// - One-shot stops counter at next update
// - Source select limits flag/DMA to overflow
// - Updates load shadows when not inhibited
// - Inhibit blocks update, still clears counters
// - Run bit starts and stops counting
// - Trigger code 000 pulses on counter reset
// - Trigger code 001 pulses on start
// - Trigger code 010 pulses on update
// - DMA enable gates update DMA requests
// - Irq enable gates update interrupt
// - Update sets flag, software writes zero
// - Software update clears counters, self-clears
// - Count register reads live, writes immediately
// - Counter clock is input over prescale plus one
// - Prescale value loads at update only
// - Reload value is the wrap limit
// - Count up to reload, wrap, update
// - One-shot run bit holds until update
`default_nettype none
package but_pkg;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_MAIN_CONTROL  = 8'h00;
    localparam logic [7:0] OFF_TRIG_CONTROL  = 8'h04;
    localparam logic [7:0] OFF_IRQ_DMA_EN    = 8'h0c;
    localparam logic [7:0] OFF_FLAG_STATUS   = 8'h10;
    localparam logic [7:0] OFF_SW_EVENT      = 8'h14;
    localparam logic [7:0] OFF_CURRENT_COUNT = 8'h24;
    localparam logic [7:0] OFF_CLOCK_DIVIDER = 8'h28;
    localparam logic [7:0] OFF_WRAP_LIMIT    = 8'h2c;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_RUN       = 0;
    localparam int BIT_INHIBIT   = 1;
    localparam int BIT_SRC_SEL   = 2;
    localparam int BIT_ONE_SHOT  = 3;
    localparam int BIT_ARB_EN    = 7;
    localparam int BIT_TRG_LO    = 4;
    localparam int BIT_IRQ_EN    = 0;
    localparam int BIT_DMA_EN    = 8;
    localparam int BIT_FLAG      = 0;
    localparam int BIT_SW_UPDATE = 0;
    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [15:0] RST_REG16   = 16'h0000;
    localparam logic [15:0] MASK_MAIN   = 16'h008f;
    localparam logic [15:0] MASK_TRIG   = 16'h0070;
    localparam logic [15:0] MASK_IRQDMA = 16'h0101;
    // Trigger output selections
    typedef enum logic [2:0] {
        TRG_RESET  = 3'b000,
        TRG_START  = 3'b001,
        TRG_UPDATE = 3'b010
    } but_trg_e;
endpackage : but_pkg
`default_nettype wire

// [logic/but_prescaler.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Prescaler: one-cycle tick every div+1 enables
// ****************************************
module but_prescaler #(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] div,
    output logic                  tick
);
    logic [WIDTH-1:0] count;
    wire              wrap = (count >= div);

    // Tick on the last input cycle of each divided period
    assign tick = run && !clear && wrap;

    // Clear restarts the period; wrap compare survives a shrinking divider
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (run) begin
            count <= wrap ? '0 : count + 1'b1;
        end
    end
endmodule : but_prescaler // but_prescaler
`default_nettype wire

// [logic/but_timer.sv]
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Basic up-counting timer with Wishbone slave
// ****************************************
module but_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    output logic             dma_req,
    output logic             trigger_output
);
    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] main_control;
    logic [15:0] trigger_output_control;
    logic [15:0] irq_dma_enables;
    logic        update_flag;
    logic [15:0] count_value;
    logic [15:0] prescale_value;
    logic [15:0] prescale_shadow;
    logic [15:0] reload_value;
    logic [15:0] reload_shadow;
    logic        sw_update_pending;
    logic        run_d;

    // Every check below runs on the one timer clock
    default clocking but_cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // ****************************************
    // Bus decode
    // ****************************************
    wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_low   = bus_req && wb_we_i && wb_sel_i[0];
    wire wr_high  = bus_req && wb_we_i && wb_sel_i[1];
    wire wr_any   = wr_low || wr_high;
    wire sel_main = (wb_adr_i == but_pkg::OFF_MAIN_CONTROL);
    wire sel_trig = (wb_adr_i == but_pkg::OFF_TRIG_CONTROL);
    wire sel_ide  = (wb_adr_i == but_pkg::OFF_IRQ_DMA_EN);
    wire sel_flag = (wb_adr_i == but_pkg::OFF_FLAG_STATUS);
    wire sel_swev = (wb_adr_i == but_pkg::OFF_SW_EVENT);
    wire sel_cnt  = (wb_adr_i == but_pkg::OFF_CURRENT_COUNT);
    wire sel_psc  = (wb_adr_i == but_pkg::OFF_CLOCK_DIVIDER);
    wire sel_car  = (wb_adr_i == but_pkg::OFF_WRAP_LIMIT);

    // Byte-lane merge of write data into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) merge16[7:0] = d[7:0];
        if (sel[1]) merge16[15:8] = d[15:8];
    endfunction

    wire [15:0] wr_main = merge16(main_control, wb_dat_i, wb_sel_i) & but_pkg::MASK_MAIN;
    wire [15:0] wr_trig = merge16(trigger_output_control, wb_dat_i, wb_sel_i) & but_pkg::MASK_TRIG;
    wire [15:0] wr_ide  = merge16(irq_dma_enables, wb_dat_i, wb_sel_i) & but_pkg::MASK_IRQDMA;
    wire [15:0] wr_cnt  = merge16(count_value, wb_dat_i, wb_sel_i);
    wire [15:0] wr_psc  = merge16(prescale_value, wb_dat_i, wb_sel_i);
    wire [15:0] wr_car  = merge16(reload_value, wb_dat_i, wb_sel_i);

    // ****************************************
    // Control fields
    // ****************************************
    wire       run_bit   = main_control[but_pkg::BIT_RUN];
    wire       inhibit   = main_control[but_pkg::BIT_INHIBIT];
    wire       src_sel   = main_control[but_pkg::BIT_SRC_SEL];
    wire       one_shot  = main_control[but_pkg::BIT_ONE_SHOT];
    wire       arb_en    = main_control[but_pkg::BIT_ARB_EN];
    wire [2:0] trg_sel   = trigger_output_control[but_pkg::BIT_TRG_LO +: 3];
    wire       irq_en    = irq_dma_enables[but_pkg::BIT_IRQ_EN];
    wire       dma_en    = irq_dma_enables[but_pkg::BIT_DMA_EN];

    // Reload limit in use: shadow when buffered, written value otherwise
    wire [15:0] limit = arb_en ? reload_shadow : reload_value;

    // ****************************************
    // Event generation
    // ****************************************
    // Software update request is latched for one cycle so the bus write
    // and the counter clear never fight over the same register.
    wire tick;
    wire overflow  = tick && (count_value >= limit);
    wire sw_clear  = sw_update_pending;
    wire upd_evt   = !inhibit && (overflow || sw_update_pending);
    wire upd_qual  = upd_evt && (!src_sel || overflow);
    wire cnt_reset = sw_update_pending || overflow;
    wire start_evt = run_bit && !run_d;

    but_prescaler #(
        .WIDTH (WIDTH)
    ) u_prescaler (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .run     (run_bit),
        .clear   (sw_clear),
        .div     (prescale_shadow),
        .tick    (tick)
    );

    wire sw_write_upd = wr_low && sel_swev && wb_dat_i[but_pkg::BIT_SW_UPDATE];

    // Trigger output selection
    logic trg_next;
    always_comb begin
        case (trg_sel)
            but_pkg::TRG_RESET:  trg_next = cnt_reset;
            but_pkg::TRG_START:  trg_next = start_evt;
            but_pkg::TRG_UPDATE: trg_next = upd_evt;
            default:             trg_next = 1'b0;
        endcase
    end

    // Read mux; unmapped addresses read zero
    wire [15:0] rd16 =
        sel_main ? main_control :
        sel_trig ? trigger_output_control :
        sel_ide  ? irq_dma_enables :
        sel_flag ? {15'h0000, update_flag} :
        sel_cnt  ? count_value :
        sel_psc  ? prescale_value :
        sel_car  ? reload_value : 16'h0000;

    // ****************************************
    // Bus answer: one wait state, ack for one cycle
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {16'h0000, rd16} : 32'h0000_0000;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_control           <= but_pkg::RST_REG16;
            trigger_output_control <= but_pkg::RST_REG16;
            irq_dma_enables        <= but_pkg::RST_REG16;
            prescale_value         <= but_pkg::RST_REG16;
            reload_value           <= but_pkg::RST_REG16;
            run_d                  <= 1'b0;
        end else begin
            run_d <= run_bit;
            if (wr_any && sel_main) begin
                main_control <= wr_main;
            end else if (one_shot && upd_evt) begin
                main_control[but_pkg::BIT_RUN] <= 1'b0;
            end
            if (wr_any && sel_trig) trigger_output_control <= wr_trig;
            if (wr_any && sel_ide)  irq_dma_enables <= wr_ide;
            if (wr_any && sel_psc)  prescale_value <= wr_psc;
            if (wr_any && sel_car)  reload_value <= wr_car;
        end
    end

    // ****************************************
    // Shadows, loaded only on an update event
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_shadow <= but_pkg::RST_REG16;
            reload_shadow   <= but_pkg::RST_REG16;
        end else if (upd_evt) begin
            prescale_shadow <= prescale_value;
            reload_shadow   <= reload_value;
        end
    end

    // ****************************************
    // Counter and software update request
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_value       <= but_pkg::RST_REG16;
            sw_update_pending <= 1'b0;
        end else begin
            sw_update_pending <= sw_write_upd;
            if (cnt_reset) begin
                count_value <= 16'h0000;
            end else if (wr_any && sel_cnt) begin
                count_value <= wr_cnt;
            end else if (tick) begin
                count_value <= count_value + 16'h0001;
            end
        end
    end

    // ****************************************
    // Flag, interrupt, DMA and trigger outputs
    // ****************************************
    // Set wins over a software write of zero in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            update_flag    <= 1'b0;
            irq            <= 1'b0;
            dma_req        <= 1'b0;
            trigger_output <= 1'b0;
        end else begin
            if (upd_qual) begin
                update_flag <= 1'b1;
            end else if (wr_low && sel_flag && !wb_dat_i[but_pkg::BIT_FLAG]) begin
                update_flag <= 1'b0;
            end
            irq            <= (update_flag || upd_qual) && irq_en;
            dma_req        <= upd_qual && dma_en;
            trigger_output <= trg_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Software update takes two steps: bus write, then the clear cycle
    sequence s_sw_write;
        sw_write_upd;
    endsequence

    // Start edge of the run bit while start pulses are selected
    sequence s_run_start;
        $rose(run_bit) && trg_sel == but_pkg::TRG_START;
    endsequence

    // ****************************************
    // Checks: bus answer and count write
    // ****************************************
    // Read data is zero outside an answer, so a stale value never leaks
    a_rdata_idle: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero between answers");
    a_rdata_upper: assert property (
        wb_dat_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_count_write: assert property (
        wr_any && sel_cnt && !cnt_reset |=> count_value == $past(wr_cnt))
        else $error("count write not applied");

    // ****************************************
    // Checks: counting and updates
    // ****************************************
    a_sw_update_clears: assert property (
        s_sw_write ##1 1'b1 |=> (count_value == 16'h0000))
        else $error("software update did not clear counter");
    // Inhibit still clears the counter but must not pulse the update trigger
    a_inhibit_blocks: assert property (
        inhibit && sw_update_pending && trg_sel == but_pkg::TRG_UPDATE
            |=> !trigger_output && count_value == 16'h0000)
        else $error("update event while inhibited");
    a_inhibit_shadow: assert property (
        inhibit |=> $stable(reload_shadow) && $stable(prescale_shadow))
        else $error("shadow loaded while inhibited");
    a_run_prescale: assert property (
        !run_bit |-> !tick)
        else $error("prescaler ticked while stopped");
    a_count_hold: assert property (
        !run_bit && !cnt_reset && !(wr_any && sel_cnt) |=> $stable(count_value))
        else $error("stopped counter moved");
    a_count_step: assert property (
        tick && !cnt_reset && !(wr_any && sel_cnt)
            |=> count_value == $past(count_value) + 16'h0001)
        else $error("counter did not advance on tick");
    a_wrap_zero: assert property (
        overflow |=> count_value == 16'h0000)
        else $error("counter did not wrap");
    a_psc_shadow: assert property (
        !upd_evt |=> $stable(prescale_shadow))
        else $error("prescale shadow changed without update");
    a_shadow_load: assert property (
        upd_evt |=> prescale_shadow == $past(prescale_value)
            && reload_shadow == $past(reload_value))
        else $error("shadow not loaded on update");
    a_one_shot_stop: assert property (
        one_shot && upd_evt && !(wr_any && sel_main) |=> !run_bit)
        else $error("one-shot did not stop");
    // Run bit may only fall by software or by the one-shot update
    a_one_shot_hold: assert property (
        one_shot && run_bit && !upd_evt && !(wr_any && sel_main) |=> run_bit)
        else $error("one-shot run bit dropped early");

    // ****************************************
    // Checks: flag, interrupt and DMA
    // ****************************************
    a_flag_sets: assert property (
        upd_qual |=> update_flag)
        else $error("update flag not set");
    a_flag_hold: assert property (
        update_flag && !(wr_low && sel_flag) |=> update_flag)
        else $error("update flag dropped without a write");
    a_flag_clear: assert property (
        wr_low && sel_flag && !wb_dat_i[but_pkg::BIT_FLAG] && !upd_qual |=> !update_flag)
        else $error("update flag not cleared by zero write");
    a_src_select: assert property (
        src_sel && !overflow |-> !upd_qual)
        else $error("software update flagged with source select");
    a_src_overflow: assert property (
        src_sel && overflow && !inhibit |=> update_flag)
        else $error("overflow not flagged with source select");
    a_irq_level: assert property (
        update_flag && irq_en && $stable(irq_dma_enables) |=> irq)
        else $error("interrupt missing");
    a_irq_off: assert property (
        !irq_en |=> !irq)
        else $error("interrupt while disabled");
    a_irq_clear: assert property (
        !update_flag && !upd_qual |=> !irq)
        else $error("interrupt without flag");
    a_dma_gate: assert property (
        !dma_en |=> !dma_req)
        else $error("dma request while disabled");
    a_dma_pulse: assert property (
        dma_en && upd_qual |=> dma_req)
        else $error("dma request missing");
    a_dma_quiet: assert property (
        !upd_qual |=> !dma_req)
        else $error("dma request without update");

    // ****************************************
    // Checks: trigger output
    // ****************************************
    // One pulse per selected event; unused codes stay silent
    a_trg_reset: assert property (
        trg_sel == but_pkg::TRG_RESET && sw_update_pending |=> trigger_output)
        else $error("trigger missing on counter reset");
    a_trg_start: assert property (
        s_run_start |=> trigger_output)
        else $error("trigger missing on start");
    a_trg_update: assert property (
        trg_sel == but_pkg::TRG_UPDATE && upd_evt |=> trigger_output)
        else $error("trigger missing on update");
    a_trg_update_only: assert property (
        trg_sel == but_pkg::TRG_UPDATE && !upd_evt |=> !trigger_output)
        else $error("trigger without update");
    a_trg_quiet: assert property (
        trg_sel > but_pkg::TRG_UPDATE |=> !trigger_output)
        else $error("trigger on unused code");
endmodule : but_timer // but_timer
`default_nettype wire

// [sim/tb_but_timer.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Register-level bench for the basic timer
// ****************************************
module tb_but_timer;
    logic        ref_clk;
    logic        reset_n;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        irq;
    logic        dma_req;
    logic        trigger_output;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    int          error_cnt;
    int          total_checks;
    int          cyc_cnt;
    int          trg_cnt;
    int          trg_at;
    int          dma_cnt;
    int          n0;
    int          i;

    but_timer #(.WIDTH(16)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .irq(irq), .dma_req(dma_req),
        .trigger_output(trigger_output)
    );

    // Clock at 125 MHz
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Pulse counters; nonblocking so tasks see them only at the next edge
    always @(posedge ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (trigger_output === 1'b1) begin
            trg_cnt <= trg_cnt + 1;
            trg_at  <= cyc_cnt;
        end
        if (dma_req === 1'b1) dma_cnt <= dma_cnt + 1;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // Wishbone classic master
    // ****************************************
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int k;
        @(posedge ref_clk);
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a;
        wb_sel <= 4'h3; wb_dat_w <= {16'h0000, d};
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        if (k >= 20) begin
            error_cnt++;
            $display("Error at %0t: no bus answer", $time);
        end
        rd_a = wb_dat_r;
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb_xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        wb_xfer(1'b0, a, 16'h0000);
        check(rd_a, {16'h0000, e});
    endtask

    // Bounded wait for a new trigger pulse
    task automatic wait_trg();
        int n;
        int k;
        n = trg_cnt;
        k = 0;
        while (trg_cnt == n && k < 500) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 500) begin
            error_cnt++;
            $display("Error at %0t: no trigger pulse", $time);
        end
    endtask

    // Write just after a pulse, then time the next two periods
    task automatic period_check(input logic [7:0] a, input logic [15:0] v,
                                input int e12, input int e23);
        int t1;
        int t2;
        wait_trg();
        t1 = trg_at;
        wr(a, v);
        wait_trg();
        t2 = trg_at;
        check(t2 - t1, e12);
        wait_trg();
        check(trg_at - t2, e23);
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        reset_n = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
        wb_adr = 8'h00; wb_sel = 4'h0; wb_dat_w = 32'h0;
        error_cnt = 0; total_checks = 0; cyc_cnt = 0; trg_cnt = 0; trg_at = 0; dma_cnt = 0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        // Reset values, unmapped word included
        rd_chk(but_pkg::OFF_MAIN_CONTROL, 16'h0000);
        rd_chk(but_pkg::OFF_TRIG_CONTROL, 16'h0000);
        rd_chk(but_pkg::OFF_IRQ_DMA_EN, 16'h0000);
        rd_chk(but_pkg::OFF_FLAG_STATUS, 16'h0000);
        rd_chk(but_pkg::OFF_CLOCK_DIVIDER, 16'h0000);
        rd_chk(but_pkg::OFF_WRAP_LIMIT, 16'h0000);
        wr(8'h08, 16'hffff);
        rd_chk(8'h08, 16'h0000);
        // Reserved bits read back as zero
        wr(but_pkg::OFF_TRIG_CONTROL, 16'hffff);
        rd_chk(but_pkg::OFF_TRIG_CONTROL, but_pkg::MASK_TRIG);
        wr(but_pkg::OFF_IRQ_DMA_EN, 16'hffff);
        rd_chk(but_pkg::OFF_IRQ_DMA_EN, but_pkg::MASK_IRQDMA);
        wr(but_pkg::OFF_IRQ_DMA_EN, 16'h0000);
        // Stopped counter takes a write and holds it
        wr(but_pkg::OFF_CURRENT_COUNT, 16'h1234);
        rd_chk(but_pkg::OFF_CURRENT_COUNT, 16'h1234);
        rd_chk(but_pkg::OFF_CURRENT_COUNT, 16'h1234);
        // Trigger codes against a software update
        for (i = 0; i < 4; i++) begin
            wr(but_pkg::OFF_TRIG_CONTROL, 16'(i << 4));
            n0 = trg_cnt;
            wr(but_pkg::OFF_SW_EVENT, 16'h0001);
            repeat (4) @(posedge ref_clk);
            check(trg_cnt - n0, (i == 0 || i == 2) ? 1 : 0);
        end
        rd_chk(but_pkg::OFF_CURRENT_COUNT, 16'h0000);
        rd_chk(but_pkg::OFF_SW_EVENT, 16'h0000);
        // Start event pulse
        wr(but_pkg::OFF_TRIG_CONTROL, 16'h0010);
        n0 = trg_cnt;
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0001);
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0000);
        check(trg_cnt - n0, 1);
        // Flag: write one keeps, write zero clears; irq gating
        rd_chk(but_pkg::OFF_FLAG_STATUS, 16'h0001);
        wr(but_pkg::OFF_FLAG_STATUS, 16'h0001);
        rd_chk(but_pkg::OFF_FLAG_STATUS, 16'h0001);
        check(irq, 1'b0);
        wr(but_pkg::OFF_IRQ_DMA_EN, 16'h0001);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b1);
        wr(but_pkg::OFF_FLAG_STATUS, 16'h0000);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b0);
        rd_chk(but_pkg::OFF_FLAG_STATUS, 16'h0000);
        // DMA gating and update source
        wr(but_pkg::OFF_IRQ_DMA_EN, 16'h0100);
        n0 = dma_cnt;
        wr(but_pkg::OFF_SW_EVENT, 16'h0001);
        repeat (4) @(posedge ref_clk);
        check(dma_cnt - n0, 1);
        wr(but_pkg::OFF_FLAG_STATUS, 16'h0000);
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0004);
        wr(but_pkg::OFF_SW_EVENT, 16'h0001);
        repeat (4) @(posedge ref_clk);
        check(dma_cnt - n0, 1);
        rd_chk(but_pkg::OFF_FLAG_STATUS, 16'h0000);
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0000);
        wr(but_pkg::OFF_IRQ_DMA_EN, 16'h0000);
        wr(but_pkg::OFF_SW_EVENT, 16'h0001);
        repeat (4) @(posedge ref_clk);
        check(dma_cnt - n0, 1);
        // Inhibit: counter still cleared, no update pulse or flag
        wr(but_pkg::OFF_FLAG_STATUS, 16'h0000);
        wr(but_pkg::OFF_TRIG_CONTROL, 16'h0020);
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0002);
        wr(but_pkg::OFF_CURRENT_COUNT, 16'h0007);
        n0 = trg_cnt;
        wr(but_pkg::OFF_SW_EVENT, 16'h0001);
        repeat (4) @(posedge ref_clk);
        check(trg_cnt - n0, 0);
        rd_chk(but_pkg::OFF_CURRENT_COUNT, 16'h0000);
        rd_chk(but_pkg::OFF_FLAG_STATUS, 16'h0000);
        // Periods: (limit+1)*(divider+1) cycles between updates
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0000);
        wr(but_pkg::OFF_CLOCK_DIVIDER, 16'h0003);
        wr(but_pkg::OFF_WRAP_LIMIT, 16'h0004);
        wr(but_pkg::OFF_SW_EVENT, 16'h0001);
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0001);
        period_check(but_pkg::OFF_WRAP_LIMIT, 16'h0002, 3 * 4, 3 * 4);
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0081);
        period_check(but_pkg::OFF_WRAP_LIMIT, 16'h0004, 3 * 4, 5 * 4);
        period_check(but_pkg::OFF_CLOCK_DIVIDER, 16'h0001, 5 * 4, 5 * 2);
        // Live read while running
        wb_xfer(1'b0, but_pkg::OFF_CURRENT_COUNT, 16'h0000);
        rd_b = rd_a;
        wb_xfer(1'b0, but_pkg::OFF_CURRENT_COUNT, 16'h0000);
        check({31'h0, rd_a !== rd_b}, 32'h1);
        rd_chk(but_pkg::OFF_MAIN_CONTROL, 16'h0081);
        // One-shot: run bit drops at the update, counter holds
        wr(but_pkg::OFF_MAIN_CONTROL, 16'h0009);
        wait_trg();
        repeat (3) @(posedge ref_clk);
        rd_chk(but_pkg::OFF_MAIN_CONTROL, 16'h0008);
        rd_chk(but_pkg::OFF_CURRENT_COUNT, 16'h0000);
        rd_chk(but_pkg::OFF_CURRENT_COUNT, 16'h0000);
        report_and_stop();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule // tb_but_timer
`default_nettype wire
